/* File: src/bsc_ctrl.sv */
// Digital control of the synchronous step-down switching regulator
`timescale 1ns/100ps
module bsc_ctrl
  import bsc_pkg::*;
#(
  parameter int SS_CYC   = SS_TIME_CYC,
  parameter int WAKE_CYC = REF_WAKE_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  input  wire logic               turn_on,
  input  wire logic               peak_cmp,
  input  wire logic               skip_peak_cmp,
  input  wire logic               zero_cross,
  input  wire logic               out_high,
  input  wire logic               out_nominal,
  input  wire logic               out_low,
  input  wire logic               overload_trip,
  input  wire logic               short_fault_detector,
  input  wire logic               low_supply_lockout,
  input  wire logic               temp_hot,
  input  wire logic               temp_cool,
  input  wire logic               dropout_req,
  output logic                    hs_gate_r,
  output logic                    ls_gate_r,
  output logic                    bleed_en_r,
  output logic                    ref_wake_r,
  output logic                    ss_active_r,
  output logic [SS_BITS-1:0]      ss_level_r,
  output logic                    skip_mode_r,
  output logic                    foldback_r,
  output logic                    hot_off_r
);

  localparam int SS_STEP = SS_CYC >> SS_BITS;
  localparam int SSW     = $clog2(SS_STEP + 1);
  localparam int WKW     = $clog2(WAKE_CYC + 1);
  localparam int DTW     = $clog2(DEAD_CYC + 1);
  localparam int ZCW     = $clog2(ZC_RUN + 1);

  generate
    if (SS_STEP < 2 || WAKE_CYC < 1) begin : g_bad
      $error("bsc_ctrl: SS_CYC or WAKE_CYC too small");
    end
  endgenerate

  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_r;
  logic [NIN-1:0] s2_r;
  logic           en_s;
  logic           pk_s;
  logic           spk_s;
  logic           zc_s;
  logic           hi_s;
  logic           nom_s;
  logic           lo_s;
  logic           ovl_s;
  logic           sh_s;
  logic           lock_s;
  logic           hot_s;
  logic           cool_s;
  logic           drop_s;

  bsc_main_t      ms_r;
  bsc_phase_t     ph_r;
  logic [WKW-1:0] wake_cnt_r;
  logic [SSW-1:0] ss_step_r;
  logic [DTW-1:0] dt_cnt_r;
  logic [ZCW-1:0] zc_cnt_r;
  logic           zc_seen_r;
  logic           skip_idle_r;
  logic           sw_ok;
  logic           dis;
  logic           dt_done;
  logic           hs_cut;
  logic           tick;

  bsc_osc_if osc_if ();

  bsc_osc #(
    .PERIOD (SW_PERIOD_CYC),
    .FOLD   (FOLD_MULT)
  ) u_osc (
    .mclk  (mclk),
    .rst_b (rst_b),
    .ce    (ce),
    .o     (osc_if)
  );

  // Pin inputs through two flip-flops
  assign raw = {dropout_req, temp_cool, temp_hot, low_supply_lockout,
                short_fault_detector, overload_trip, out_low, out_nominal,
                out_high, zero_cross, skip_peak_cmp, peak_cmp, turn_on};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  assign en_s   = s2_r[IX_TURN_ON];
  assign pk_s   = s2_r[IX_PEAK];
  assign spk_s  = s2_r[IX_SKIP_PEAK];
  assign zc_s   = s2_r[IX_ZC];
  assign hi_s   = s2_r[IX_OUT_HIGH];
  assign nom_s  = s2_r[IX_OUT_NOM];
  assign lo_s   = s2_r[IX_OUT_LOW];
  assign ovl_s  = s2_r[IX_OVL];
  assign sh_s   = s2_r[IX_SHORT];
  assign lock_s = s2_r[IX_LOCK];
  assign hot_s  = s2_r[IX_HOT];
  assign cool_s = s2_r[IX_COOL];
  assign drop_s = s2_r[IX_DROP];

  assign dis   = !en_s || lock_s;
  assign sw_ok = (ms_r == MS_SOFT) || (ms_r == MS_RUN);
  assign tick  = osc_if.tick;

  assign osc_if.run  = sw_ok;
  assign osc_if.fold = sh_s;

  // Start-up, shutdown and restart sequencing
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ms_r       <= MS_OFF;
      wake_cnt_r <= '0;
    end else if (ce) begin
      if (dis) begin
        ms_r       <= MS_OFF;
        wake_cnt_r <= '0;
      end else if (hot_s) begin
        ms_r       <= MS_HOT;
        wake_cnt_r <= '0;
      end else begin
        case (ms_r)
          MS_OFF: begin
            ms_r <= MS_WAKE;
          end
          MS_WAKE: begin
            if (wake_cnt_r >= WKW'(WAKE_CYC - 1)) begin
              ms_r       <= MS_SOFT;
              wake_cnt_r <= '0;
            end else begin
              wake_cnt_r <= wake_cnt_r + 1'b1;
            end
          end
          MS_SOFT: begin
            if (ss_level_r == SS_TOP && ss_step_r >= SSW'(SS_STEP - 1)) begin
              ms_r <= MS_RUN;
            end
          end
          MS_RUN: begin
            ms_r <= MS_RUN;
          end
          MS_HOT: begin
            if (cool_s) begin
              ms_r <= MS_WAKE;
            end
          end
          default: begin
            ms_r <= MS_OFF;
          end
        endcase
      end
    end
  end

  // Soft-start ramp, stepped while starting and held at SS_TOP in run
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ss_level_r  <= SS_RST;
      ss_step_r   <= '0;
      ss_active_r <= 1'b0;
    end else if (ce) begin
      if (ms_r == MS_SOFT) begin
        ss_active_r <= 1'b1;
        if (ss_step_r >= SSW'(SS_STEP - 1)) begin
          ss_step_r <= '0;
          if (ss_level_r != SS_TOP) begin
            ss_level_r <= ss_level_r + 1'b1;
          end
        end else begin
          ss_step_r <= ss_step_r + 1'b1;
        end
      end else if (ms_r == MS_RUN) begin
        ss_active_r <= 1'b0;
        ss_level_r  <= SS_TOP;
        ss_step_r   <= '0;
      end else begin
        ss_active_r <= 1'b0;
        ss_level_r  <= SS_RST;
        ss_step_r   <= '0;
      end
    end
  end

  // Status and housekeeping outputs
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bleed_en_r <= 1'b0;
      ref_wake_r <= 1'b0;
      foldback_r <= 1'b0;
      hot_off_r  <= 1'b0;
    end else if (ce) begin
      bleed_en_r <= !en_s;
      ref_wake_r <= !dis && (ms_r != MS_OFF) && (ms_r != MS_HOT);
      foldback_r <= sw_ok && sh_s;
      hot_off_r  <= (ms_r == MS_HOT);
    end
  end

  // Zero-cross run counter and skip mode entry and exit
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      zc_cnt_r    <= '0;
      zc_seen_r   <= 1'b0;
      skip_mode_r <= 1'b0;
    end else if (ce) begin
      if (!sw_ok) begin
        zc_cnt_r    <= '0;
        zc_seen_r   <= 1'b0;
        skip_mode_r <= 1'b0;
      end else if (skip_mode_r) begin
        zc_cnt_r  <= '0;
        zc_seen_r <= 1'b0;
        if (lo_s) begin
          skip_mode_r <= 1'b0;
        end
      end else if (tick) begin
        zc_seen_r <= 1'b0;
        if (zc_seen_r || zc_s) begin
          if (zc_cnt_r >= ZCW'(ZC_RUN - 1)) begin
            zc_cnt_r    <= '0;
            skip_mode_r <= 1'b1;
          end else begin
            zc_cnt_r <= zc_cnt_r + 1'b1;
          end
        end else begin
          zc_cnt_r <= '0;
        end
      end else if (zc_s) begin
        zc_seen_r <= 1'b1;
      end
    end
  end

  // Skip idle: set by output high, cleared at nominal
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      skip_idle_r <= 1'b0;
    end else if (ce) begin
      if (!sw_ok || !skip_mode_r) begin
        skip_idle_r <= 1'b0;
      end else if (hi_s) begin
        skip_idle_r <= 1'b1;
      end else if (nom_s) begin
        skip_idle_r <= 1'b0;
      end
    end
  end

  // High-side off conditions while it conducts
  always_comb begin
    hs_cut = 1'b0;
    if (ovl_s) begin
      hs_cut = 1'b1;
    end else if (skip_mode_r) begin
      hs_cut = spk_s || hi_s;
    end else if (pk_s && !drop_s) begin
      hs_cut = 1'b1;
    end
  end

  assign dt_done = (dt_cnt_r >= DTW'(DEAD_CYC - 1));

  // Gate sequencing within each switching cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ph_r      <= PH_OFF;
      hs_gate_r <= 1'b0;
      ls_gate_r <= 1'b0;
      dt_cnt_r  <= '0;
    end else if (ce) begin
      if (!sw_ok) begin
        ph_r      <= PH_OFF;
        hs_gate_r <= 1'b0;
        ls_gate_r <= 1'b0;
        dt_cnt_r  <= '0;
      end else begin
        case (ph_r)
          PH_OFF: begin
            if (tick && !(skip_mode_r && (skip_idle_r || hi_s))) begin
              ph_r     <= PH_DEAD_H;
              dt_cnt_r <= '0;
            end
          end
          PH_DEAD_H: begin
            if (dt_done) begin
              hs_gate_r <= 1'b1;
              ph_r      <= PH_HIGH;
            end else begin
              dt_cnt_r <= dt_cnt_r + 1'b1;
            end
          end
          PH_HIGH: begin
            if (hs_cut) begin
              hs_gate_r <= 1'b0;
              ph_r      <= PH_DEAD_L;
              dt_cnt_r  <= '0;
            end
          end
          PH_DEAD_L: begin
            if (skip_mode_r && (skip_idle_r || hi_s)) begin
              ph_r <= PH_OFF;
            end else if (dt_done) begin
              ls_gate_r <= 1'b1;
              ph_r      <= PH_LOW;
            end else begin
              dt_cnt_r <= dt_cnt_r + 1'b1;
            end
          end
          PH_LOW: begin
            if (tick) begin
              ls_gate_r <= 1'b0;
              ph_r      <= (skip_mode_r && (skip_idle_r || hi_s)) ? PH_OFF : PH_DEAD_H;
              dt_cnt_r  <= '0;
            end else if (skip_mode_r && zc_s) begin
              ls_gate_r <= 1'b0;
              ph_r      <= PH_OFF;
            end
          end
          default: begin
            ph_r      <= PH_OFF;
            hs_gate_r <= 1'b0;
            ls_gate_r <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : bsc_ctrl

/* File: src/bsc_osc.sv */
// Switching cycle oscillator with short-circuit foldback
`timescale 1ns/100ps
module bsc_osc
  import bsc_pkg::*;
#(
  parameter int PERIOD = SW_PERIOD_CYC,
  parameter int FOLD   = FOLD_MULT
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  bsc_osc_if.osc   o
);

  localparam int CW = $clog2(PERIOD * FOLD + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] last;

  generate
    if (PERIOD < 4 || FOLD < 2) begin : g_bad
      $error("bsc_osc: PERIOD must be >= 4 and FOLD >= 2");
    end
  endgenerate

  // Slow cycle while the short fault is reported
  assign last = o.fold ? CW'(PERIOD * FOLD - 1) : CW'(PERIOD - 1);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r  <= '0;
      o.tick <= 1'b0;
    end else if (ce) begin
      if (!o.run) begin
        cnt_r  <= '0;
        o.tick <= 1'b0;
      end else if (cnt_r >= last) begin
        cnt_r  <= '0;
        o.tick <= 1'b1;
      end else begin
        cnt_r  <= cnt_r + 1'b1;
        o.tick <= 1'b0;
      end
    end
  end

endmodule : bsc_osc

/* File: src/bsc_osc_if.sv */
// Link between the controller and its cycle oscillator
`timescale 1ns/100ps
interface bsc_osc_if;
  logic run;
  logic fold;
  logic tick;

  modport ctrl (
    output run,
    output fold,
    input  tick
  );

  modport osc (
    input  run,
    input  fold,
    output tick
  );
endinterface : bsc_osc_if

/* File: src/bsc_pkg.sv */
// Shared constants and types of the buck switching controller
package bsc_pkg;

  // Clock period of mclk (20 MHz)
  localparam int CLK_NS       = 50;

  // Gate non-overlap time, rounded up, never under one cycle
  localparam int DEAD_NS      = 40;
  localparam int DEAD_RAW     = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_CYC     = (DEAD_RAW < 1) ? 1 : DEAD_RAW;

  // Switching cycle period and short-circuit foldback factor
  localparam int SW_PERIOD_NS = 1000;
  localparam int SW_PERIOD_CYC = SW_PERIOD_NS / CLK_NS;
  localparam int FOLD_MULT    = 8;

  // Reference wake-up time before soft-start
  localparam int REF_WAKE_US  = 50;
  localparam int REF_WAKE_CYC = REF_WAKE_US * 1000 / CLK_NS;

  // Soft-start ramp time
  localparam int SS_TIME_US   = 1000;
  localparam int SS_TIME_CYC  = SS_TIME_US * 1000 / CLK_NS;
  localparam int SS_BITS      = 8;

  // Consecutive zero-cross cycles before skip mode
  localparam int ZC_RUN       = 16;

  // Positions of the synchronised analog indications
  localparam int IX_TURN_ON   = 0;
  localparam int IX_PEAK      = 1;
  localparam int IX_SKIP_PEAK = 2;
  localparam int IX_ZC        = 3;
  localparam int IX_OUT_HIGH  = 4;
  localparam int IX_OUT_NOM   = 5;
  localparam int IX_OUT_LOW   = 6;
  localparam int IX_OVL       = 7;
  localparam int IX_SHORT     = 8;
  localparam int IX_LOCK      = 9;
  localparam int IX_HOT       = 10;
  localparam int IX_COOL      = 11;
  localparam int IX_DROP      = 12;
  localparam int NIN          = 13;

  // Values after reset, and the top level of the soft-start ramp
  localparam logic [NIN-1:0]     SYNC_RST = 13'h0000;
  localparam logic [SS_BITS-1:0] SS_RST   = 8'h00;
  localparam logic [SS_BITS-1:0] SS_TOP   = 8'hff;

  typedef enum logic [2:0] {
    MS_OFF,
    MS_WAKE,
    MS_SOFT,
    MS_RUN,
    MS_HOT
  } bsc_main_t;

  typedef enum logic [2:0] {
    PH_OFF,
    PH_DEAD_H,
    PH_HIGH,
    PH_DEAD_L,
    PH_LOW
  } bsc_phase_t;

endpackage : bsc_pkg

/* File: verification/bsc_monitor.sv */
// Concurrent checks on the controller ports
`timescale 1ns/100ps
module bsc_monitor
  import bsc_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_b,
  input wire logic               peak_cmp,
  input wire logic               skip_peak_cmp,
  input wire logic               out_high,
  input wire logic               overload_trip,
  input wire logic               low_supply_lockout,
  input wire logic               dropout_req,
  input wire logic               hs_gate_r,
  input wire logic               ls_gate_r,
  input wire logic               bleed_en_r,
  input wire logic               ref_wake_r,
  input wire logic               ss_active_r,
  input wire logic               skip_mode_r,
  input wire logic               hot_off_r
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Peak trip held long enough to pass the synchroniser
  sequence s_peak_held;
    (peak_cmp && !dropout_req)[*4];
  endsequence
  // Low side released at a cycle start in PWM
  sequence s_tick_end;
    $fell(ls_gate_r) && !skip_mode_r && !bleed_en_r && !hot_off_r && !low_supply_lockout;
  endsequence

  a_gates_apart: assert property (!(hs_gate_r && ls_gate_r))
    else $error("both gates on");
  a_high_gap: assert property ($rose(hs_gate_r) |-> !$past(ls_gate_r))
    else $error("no dead time before high side");
  a_low_gap: assert property ($rose(ls_gate_r) |-> !$past(hs_gate_r))
    else $error("no dead time before low side");
  a_pulse_start: assert property (s_tick_end |-> ##1 hs_gate_r)
    else $error("no high side pulse after cycle start");
  a_peak_cut: assert property (s_peak_held |-> !hs_gate_r)
    else $error("high side not cut by peak");
  a_skip_cut: assert property (((skip_peak_cmp || out_high) && skip_mode_r)[*4] |-> !hs_gate_r)
    else $error("skip pulse not cut");
  a_ovl_cut: assert property (overload_trip[*4] |-> !hs_gate_r)
    else $error("overload not cut");
  a_bleed_quiet: assert property (bleed_en_r[*2] |-> !hs_gate_r && !ls_gate_r)
    else $error("switching while disabled");
  a_lock_quiet: assert property (low_supply_lockout[*5] |-> !hs_gate_r && !ls_gate_r)
    else $error("switching in lockout");
  a_hot_quiet: assert property (hot_off_r[*2] |-> !hs_gate_r && !ls_gate_r)
    else $error("switching while hot");
  a_ref_first: assert property ($rose(ss_active_r) |-> $past(ref_wake_r, 3))
    else $error("soft-start before reference");
endmodule : bsc_monitor

bind bsc_ctrl bsc_monitor mon_u (.*);

/* File: verification/bsc_stage_model.sv */
// Power stage and comparator model facing the controller
`timescale 1ns/100ps
module bsc_stage_model #(
  parameter int PK_CYC = 5
) (
  input  wire logic mclk,
  input  wire logic hs_gate_r,
  input  wire logic ls_gate_r,
  input  wire logic light,
  output logic      peak_cmp,
  output logic      skip_peak_cmp,
  output logic      zero_cross
);
  int hs_cnt;
  int ls_cnt;
  // On-time counters stand in for inductor current
  always_ff @(posedge mclk) begin
    hs_cnt <= hs_gate_r ? hs_cnt + 1 : 0;
    ls_cnt <= ls_gate_r ? ls_cnt + 1 : 0;
  end
  assign peak_cmp      = (hs_cnt >= PK_CYC);
  assign skip_peak_cmp = (hs_cnt >= 2);
  assign zero_cross    = light && (ls_cnt >= 3);
endmodule : bsc_stage_model

/* File: verification/bsc_tb.sv */
// Self-checking bench of the buck switching controller
`timescale 1ns/100ps
module tb;
  import bsc_pkg::*;
  logic               mclk, rst_b, ce, turn_on, light, out_high, out_nominal, out_low;
  logic               overload_trip, short_fault_detector, low_supply_lockout, temp_hot;
  logic               temp_cool, dropout_req, peak_cmp, skip_peak_cmp, zero_cross;
  logic               hs_gate_r, ls_gate_r, bleed_en_r, ref_wake_r, ss_active_r;
  logic               skip_mode_r, foldback_r, hot_off_r;
  logic [SS_BITS-1:0] ss_level_r;
  int                 err_count, cmp_count, cyc;

  bsc_ctrl #(.SS_CYC(512), .WAKE_CYC(4)) dut_u (.*);
  bsc_stage_model model_u (.*);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk

  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  task automatic wait_lvl(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 800) begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_lvl

  task automatic hs_rise(output int n);
    logic p = 1'b1;
    n = 0;
    while (n < 400 && !(p === 1'b0 && hs_gate_r === 1'b1)) begin
      p = hs_gate_r;
      @(posedge mclk);
      n++;
    end
  endtask : hs_rise

  task automatic t_start;
    wait_lvl(ref_wake_r, 1'b1);
    chk(ref_wake_r, 1'b1, "no reference wake");
    chk(ss_active_r, 1'b0, "soft-start early");
    wait_lvl(ss_active_r, 1'b1);
    wait_lvl(ss_active_r, 1'b0);
    chk(ss_level_r, SS_TOP, "ramp end");
  endtask : t_start

  task automatic t_period(input int exp);
    int n;
    hs_rise(n);
    hs_rise(n);
    chk(8'(n), 8'(exp), "switch period");
  endtask : t_period

  // Freezes the clock enable while the low side conducts
  task automatic t_hold;
    logic [7:0] v, c;
    repeat (12) @(posedge mclk);
    ce <= 1'b0;
    repeat (2) @(posedge mclk);
    v = {hs_gate_r, ls_gate_r, bleed_en_r, ref_wake_r, ss_active_r, skip_mode_r, foldback_r, hot_off_r};
    c = 8'h00;
    repeat (45) begin
      @(posedge mclk);
      if ({hs_gate_r, ls_gate_r, bleed_en_r, ref_wake_r, ss_active_r, skip_mode_r, foldback_r,
           hot_off_r} !== v) c++;
    end
    ce <= 1'b1;
    chk(c, 8'h00, "state moved while frozen");
  endtask : t_hold

  task automatic t_fold;
    short_fault_detector <= 1'b1;
    t_period(SW_PERIOD_CYC * FOLD_MULT);
    chk(foldback_r, 1'b1, "no foldback");
    short_fault_detector <= 1'b0;
    t_period(SW_PERIOD_CYC);
    chk(foldback_r, 1'b0, "foldback stuck");
  endtask : t_fold

  // Counts edges over a window where the high side is not on (hs_only) or the gates are not both off
  task automatic gate_on(input int k, input logic hs_only, output logic [7:0] c);
    c = 8'h00;
    repeat (k) begin
      @(posedge mclk);
      if (hs_gate_r !== hs_only || (!hs_only && ls_gate_r !== 1'b0)) c++;
    end
  endtask : gate_on

  task automatic t_drop;
    logic [7:0] c;
    dropout_req <= 1'b1;
    repeat (25) @(posedge mclk);
    gate_on(60, 1'b1, c);
    chk(c, 8'h00, "duty gap");
    overload_trip <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(hs_gate_r, 1'b0, "overload ignored");
    {overload_trip, dropout_req} <= 2'b00;
  endtask : t_drop

  task automatic t_skip;
    int n;
    logic [7:0] c;
    light <= 1'b1;
    repeat (8) hs_rise(n);
    light <= 1'b0;
    repeat (2) hs_rise(n);
    light <= 1'b1;
    repeat (15) hs_rise(n);
    chk(skip_mode_r, 1'b0, "early skip");
    repeat (2) hs_rise(n);
    chk(skip_mode_r, 1'b1, "no skip");
    out_high <= 1'b1;
    repeat (6) @(posedge mclk);
    gate_on(60, 1'b0, c);
    chk(c, 8'h00, "pulse while high");
    {out_high, out_nominal} <= 2'b01;
    hs_rise(n);
    chk(hs_gate_r, 1'b1, "no resume");
    {out_nominal, out_low, light} <= 3'b010;
    repeat (5) @(posedge mclk);
    chk(skip_mode_r, 1'b0, "skip stuck");
    out_low <= 1'b0;
  endtask : t_skip

  task automatic t_stop;
    logic [7:0] c;
    turn_on <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({hs_gate_r, ls_gate_r, bleed_en_r}, 8'h01, "not shut off");
    {turn_on, low_supply_lockout} <= 2'b11;
    gate_on(100, 1'b0, c);
    chk(c, 8'h00, "switching in lockout");
    low_supply_lockout <= 1'b0;
    t_start();
    temp_hot <= 1'b1;
    repeat (5) @(posedge mclk);
    chk({hs_gate_r, ls_gate_r, hot_off_r}, 8'h01, "no thermal stop");
    chk(ref_wake_r, 1'b0, "reference awake while hot");
    {temp_hot, temp_cool} <= 2'b01;
    t_start();
    chk(hot_off_r, 1'b0, "still hot");
    temp_cool <= 1'b0;
  endtask : t_stop

  initial begin
    mclk = 1'b0;
    forever #(CLK_NS / 2) mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end

  initial begin
    ce = 1'b1;
    {rst_b, turn_on, light, out_high, out_nominal, out_low, overload_trip} = '0;
    {short_fault_detector, low_supply_lockout, temp_hot, temp_cool, dropout_req} = '0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    turn_on <= 1'b1;
    t_start();
    t_period(SW_PERIOD_CYC);
    t_hold();
    t_fold();
    t_drop();
    t_skip();
    t_stop();
    end_sim();
  end
endmodule : tb
